// ### core/lbs_pkg.sv
// package of constants for the lcd bias and supply control block
`default_nettype none
package lbs_pkg;
   // bus register byte offsets
   localparam logic [7:0] LBS_CTRL_OFS   = 8'h00;
   localparam logic [7:0] LBS_STATUS_OFS = 8'h04;
   localparam logic [7:0] LBS_MEM_OFS    = 8'h10;
   localparam int         LBS_MEM_WORDS  = 4;
   localparam int         LBS_SEG_PINS   = 32;
   // control field positions
   localparam int CTRL_ON      = 0;
   localparam int CTRL_SON     = 1;
   localparam int CTRL_AUX_OSCILLATOR_OFF  = 2;
   localparam int CTRL_MUX_LO  = 3;
   localparam int CTRL_HALF    = 5;
   localparam int CTRL_EXTSUP  = 6;
   localparam int CTRL_PEN     = 7;
   localparam int CTRL_CPEN    = 8;
   localparam int CTRL_EXTERNAL_BIAS_SELECT    = 9;
   localparam int CTRL_EXTERNAL_LOWEST_LEVEL_SELECT  = 10;
   localparam int CTRL_LVL_LO  = 12;
   localparam int CTRL_REF_LO  = 16;
   localparam int CTRL_PREF_LO = 18;
   localparam logic [31:0] LBS_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] LBS_CTRL_MASK  = 32'h000f_f7ff;
   // status field positions
   localparam int ST_SRC_LO   = 0;
   localparam int ST_PUMP_RUN = 2;
   localparam int ST_HOLD     = 3;
   localparam int ST_REF3X    = 4;
   localparam int ST_DIV_ON   = 5;
   localparam int ST_HALF     = 6;
   localparam int ST_RAIL_OUT = 7;
   localparam int ST_RAIL_IN  = 8;
   localparam int ST_V5_EXT   = 9;
   localparam int ST_GEN_ON   = 10;
   localparam int ST_COMS_LO  = 12;
   // peak supply source codes, static mux code and external pump reference code
   localparam logic [1:0] SRC_NONE = 2'h0;
   localparam logic [1:0] SRC_AVCC = 2'h1;
   localparam logic [1:0] SRC_PUMP = 2'h2;
   localparam logic [1:0] SRC_EXT  = 2'h3;
   localparam logic [1:0] MUX_STATIC = 2'h0;
   localparam logic [1:0] PREF_EXT   = 2'h1;
endpackage
`default_nettype wire

// ### core/lbs_top.sv
// lcd bias and supply control with ahb-lite register slave
`default_nettype none
module lbs_top
   import lbs_pkg::*;
#(
   parameter bit LOWEST_PIN_PRESENT = 1'b1
) (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rstn,
   // ahb-lite slave
   input  wire logic                  hsel,
   input  wire logic [7:0]            haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // segment enables per memory bit, one per segment and common phase
   output logic      [4*LBS_SEG_PINS-1:0] seg_on,
   output logic      [3:0]            com_enable,
   // supply and bias controls toward the analog section
   output logic      [1:0]            supply_source,
   output logic                       pump_run,
   output logic      [3:0]            pump_level,
   output logic                       pump_ref3x,
   output logic                       bias_div_on,
   output logic                       bias_half,
   output logic                       rail_pin_drive,
   output logic                       lowest_from_pin,
   output logic                       lowest_to_agnd
);
   ////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   logic rst_meta_n;
   logic rst_n;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ahb-lite address phase capture
   logic        wr_pend;
   logic        rd_pend;
   logic [7:0]  addr_q;
   logic        take;
   assign take = hsel && hready && htrans[1];
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr_q  <= 8'h00;
      end else begin
         wr_pend <= take && hwrite;
         rd_pend <= take && !hwrite;
         if (take) begin
            addr_q <= haddr;
         end
      end
   end

   // zero wait states, always okay
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control register
   logic [31:0] ctrl;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= LBS_CTRL_RESET;
      end else if (wr_pend && addr_q == LBS_CTRL_OFS) begin
         ctrl <= hwdata & LBS_CTRL_MASK;
      end
   end

   // display memory; unchanged by reset in the real part, cleared here for x safety
   logic [31:0] disp_mem [LBS_MEM_WORDS];
   genvar gi;
   generate
      for (gi = 0; gi < LBS_MEM_WORDS; gi++) begin : g_mem
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               disp_mem[gi] <= 32'h0000_0000;
            end else if (wr_pend && addr_q == LBS_MEM_OFS + 8'(4 * gi)) begin
               disp_mem[gi] <= hwdata;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // field decode
   logic       mod_on;
   logic       seg_vis;
   logic       osc_off;
   logic [1:0] mux_sel;
   logic       half_sel;
   logic       ext_sup;
   logic       pen;
   logic       cpen;
   logic       external_bias_select;
   logic       external_lowest_level_select;
   logic [3:0] lvl;
   logic [1:0] refalt;
   logic [1:0] pref;
   logic       gen_ok;
   assign mod_on   = ctrl[CTRL_ON];
   assign seg_vis  = ctrl[CTRL_SON];
   assign osc_off  = ctrl[CTRL_AUX_OSCILLATOR_OFF];
   assign mux_sel  = ctrl[CTRL_MUX_LO +: 2];
   assign half_sel = ctrl[CTRL_HALF];
   assign ext_sup  = ctrl[CTRL_EXTSUP];
   assign pen      = ctrl[CTRL_PEN];
   assign cpen     = ctrl[CTRL_CPEN];
   assign external_bias_select     = ctrl[CTRL_EXTERNAL_BIAS_SELECT];
   assign external_lowest_level_select   = ctrl[CTRL_EXTERNAL_LOWEST_LEVEL_SELECT];
   assign lvl      = ctrl[CTRL_LVL_LO +: 4];
   assign refalt   = ctrl[CTRL_REF_LO +: 2];
   assign pref     = ctrl[CTRL_PREF_LO +: 2];
   assign gen_ok   = mod_on && !osc_off;

   // supply selection; software keeps the shared-pin restriction
   logic [1:0] next_src;
   logic       next_pump;
   logic       next_hold;
   always_comb begin
      next_src  = SRC_NONE;
      next_pump = 1'b0;
      next_hold = 1'b0;
      if (ext_sup) begin
         next_src = SRC_EXT;
      end else if (!gen_ok) begin
         next_src = SRC_NONE;
      end else if (pen && (lvl != 4'h0 || pref == PREF_EXT)) begin
         next_src  = SRC_PUMP;
         next_hold = !cpen;
         next_pump = cpen;
      end else if (lvl == 4'h0 && refalt == 2'h0) begin
         next_src = SRC_AVCC;
      end
   end

   // per-mode common count
   logic [3:0] next_com;
   always_comb begin
      unique case (mux_sel)
         2'h0: next_com = 4'h1;
         2'h1: next_com = 4'h3;
         2'h2: next_com = 4'h7;
         2'h3: next_com = 4'hf;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // registered analog controls
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         supply_source   <= SRC_NONE;
         pump_run        <= 1'b0;
         pump_level      <= 4'h0;
         pump_ref3x      <= 1'b0;
         com_enable      <= 4'h0;
      end else begin
         supply_source   <= next_src;
         pump_run        <= next_pump;
         pump_level      <= (pref == PREF_EXT) ? 4'h0 : lvl;
         pump_ref3x      <= next_pump && pref == PREF_EXT;
         com_enable      <= mod_on ? next_com : 4'h0;
      end
   end

   // bias divider and pin roles; collisions with the cap pin are software's concern
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bias_div_on     <= 1'b0;
         bias_half       <= 1'b0;
         rail_pin_drive  <= 1'b0;
         lowest_from_pin <= 1'b0;
         lowest_to_agnd  <= 1'b0;
      end else begin
         bias_div_on     <= gen_ok && !external_bias_select && mux_sel != MUX_STATIC;
         bias_half       <= half_sel && mux_sel != MUX_STATIC;
         rail_pin_drive  <= external_bias_select && !ext_sup && mod_on;
         lowest_from_pin <= external_lowest_level_select && LOWEST_PIN_PRESENT;
         lowest_to_agnd  <= !LOWEST_PIN_PRESENT;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // segment gating: phase p of pin s uses memory bit 4*s+p
   generate
      for (gi = 0; gi < 4 * LBS_SEG_PINS; gi++) begin : g_seg
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               seg_on[gi] <= 1'b0;
            end else begin
               seg_on[gi] <= disp_mem[gi / 32][gi % 32] && seg_vis
                             && next_com[gi % 4] && mod_on;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // read data
   logic [31:0] status;
   // rail input flag reads the pin role: external divider fed from the external supply
   assign status = {16'h0, next_com, 1'b0, gen_ok, lowest_from_pin, external_bias_select && ext_sup,
                    rail_pin_drive, bias_half, bias_div_on, pump_ref3x,
                    next_hold, pump_run, supply_source};
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (take && !hwrite) begin
         if (haddr == LBS_CTRL_OFS) begin
            next_rdata = ctrl;
         end else if (haddr == LBS_STATUS_OFS) begin
            next_rdata = status;
         end else if (haddr >= LBS_MEM_OFS && haddr < LBS_MEM_OFS + 8'h10) begin
            next_rdata = disp_mem[haddr[3:2]];
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (take) begin
         hrdata <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// ### verification/lbs_panel.sv
// passive segment panel model: counts segments darkened on the glass
`default_nettype none
module lbs_panel
   import lbs_pkg::*;
(
   // drive from the controller
   input  wire logic [4*LBS_SEG_PINS-1:0] seg_on,
   input  wire logic [3:0]                com_enable,
   // what an observer sees
   output logic      [7:0]                lit_count
);
   timeunit 1ns;
   timeprecision 1ps;
   // a segment darkens only while its common is driven; orphan bits stay clear
   always_comb begin
      lit_count = 8'h00;
      for (int i = 0; i < 4*LBS_SEG_PINS; i++)
         lit_count += 8'(seg_on[i] & com_enable[i%4]);
   end
endmodule
`default_nettype wire

// ### verification/lbs_top_properties.sv
// port assertions for the lcd bias and supply control block
`default_nettype none
module lbs_checker
   import lbs_pkg::*;
(
   // clock, reset and bus
   input wire logic                      core_clk,
   input wire logic                      rstn,
   input wire logic                      hsel,
   input wire logic [7:0]                haddr,
   input wire logic [1:0]                htrans,
   input wire logic                      hwrite,
   input wire logic                      hready,
   input wire logic [31:0]               hwdata,
   input wire logic                      hreadyout,
   input wire logic                      hresp,
   // display and supply controls
   input wire logic [4*LBS_SEG_PINS-1:0] seg_on,
   input wire logic [3:0]                com_enable,
   input wire logic [1:0]                supply_source,
   input wire logic                      pump_run,
   input wire logic                      bias_div_on
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // write to control: data follows one edge later, outputs two edges after that
   wire logic wr_ctrl = hsel && hready && htrans[1] && hwrite && haddr == LBS_CTRL_OFS;
   property p_com_follow;
      logic [31:0] d;
      wr_ctrl ##1 (1, d = hwdata) |->
         ##2 com_enable == ({d[4:3] == 2'h3, d[4], d[4:3] != 2'h0, 1'b1} & {4{d[0]}});
   endproperty
   property p_off_kills;
      logic [31:0] d;
      wr_ctrl ##1 (1, d = hwdata) ##0 (!d[0] || d[2]) |-> ##2 !pump_run && !bias_div_on;
   endproperty
   a_com_follow: assert property (p_com_follow) else $error("commons mismatch");
   a_off_kills: assert property (p_off_kills) else $error("generation not off");
   a_pump_source: assert property (pump_run |-> supply_source == SRC_PUMP)
      else $error("pump runs without pump source");
   a_ext_no_pump: assert property (supply_source == SRC_EXT |-> !pump_run)
      else $error("pump runs on external supply");
   a_static_div_off: assert property (com_enable == 4'h1 |-> !bias_div_on)
      else $error("divider on in static mode");
   a_off_quiet: assert property (com_enable == 4'h0 |-> !pump_run && !bias_div_on)
      else $error("generation while module off");
   a_phase_unused: assert property (!com_enable[3] |-> (seg_on & {LBS_SEG_PINS{4'h8}}) == '0)
      else $error("unmapped phase drives segment");
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or error");
   // main scenarios reached
   c_pump: cover property (pump_run);
   c_ext: cover property (supply_source == SRC_EXT);
   c_static: cover property (com_enable == 4'h1);
   c_four: cover property (com_enable == 4'hf && bias_div_on);
endmodule
bind lbs_top lbs_checker lbs_checker_inst (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
   .hreadyout(hreadyout), .hresp(hresp), .seg_on(seg_on), .com_enable(com_enable),
   .supply_source(supply_source), .pump_run(pump_run), .bias_div_on(bias_div_on));
`default_nettype wire

// ### verification/lbs_top_tb.sv
// self-checking bench for the lcd bias and supply control block
`default_nettype none
module lbs_top_tb;
   import lbs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rstn, hsel, hwrite, hreadyout, hresp, pump_run, pump_ref3x;
   logic bias_div_on, bias_half, rail_pin_drive, lowest_from_pin, lowest_to_agnd;
   logic [7:0] haddr, lit_count;
   logic [1:0] htrans, supply_source;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd, c, st;
   logic [127:0] seg_on, es;
   logic [3:0] com_enable, pump_level;
   logic [31:0] mem [4];
   int fail_count, checked;
   lbs_top lbs_top_inst (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .seg_on(seg_on),
      .com_enable(com_enable), .supply_source(supply_source), .pump_run(pump_run),
      .pump_level(pump_level), .pump_ref3x(pump_ref3x), .bias_div_on(bias_div_on),
      .bias_half(bias_half), .rail_pin_drive(rail_pin_drive),
      .lowest_from_pin(lowest_from_pin), .lowest_to_agnd(lowest_to_agnd));
   lbs_panel lbs_panel_inst (.seg_on(seg_on), .com_enable(com_enable), .lit_count(lit_count));
   // 250 mhz clock; the slow frame clock tolerance is kept by the system, not here
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one single transfer; the wait is bounded, never trusting a fixed latency
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 100);
      rd = hrdata;
      if (n >= 100) begin
         fail_count++;
         end_of_test();
      end
   endtask
   // reference model of every control output from the control word and memory
   task automatic expect_all;
      logic gen, psel, div;
      int ncom;
      gen = c[0] && !c[2];
      ncom = c[4:3] + 1;
      psel = !c[6] && c[7] && (c[15:12] != 4'h0 || c[19:18] == PREF_EXT);
      div = gen && !c[9] && c[4:3] != MUX_STATIC;
      for (int b = 0; b < 128; b++)
         es[b] = c[1] && (b % 4 < ncom) && mem[b/32][b%32];
      if (c[0]) chk(seg_on, es);
      if (c[0]) chk(lit_count, $countones(es));
      chk(com_enable, c[0] ? (1 << ncom) - 1 : 0);
      chk(pump_run, gen && psel && c[8]);
      chk(bias_div_on, div);
      chk(lowest_from_pin, c[10]);
      if (gen) chk(supply_source, c[6] ? SRC_EXT : psel ? SRC_PUMP :
         (c[15:12] == 4'h0 && c[17:16] == 2'h0) ? SRC_AVCC : SRC_NONE);
      if (div) chk(bias_half, c[5]);
      if (gen && psel && c[19:18] != PREF_EXT) chk(pump_level, c[15:12]);
      if (gen && psel) chk(pump_ref3x, c[8] && c[19:18] == PREF_EXT);
      if (c[19:18] == PREF_EXT) chk(pump_level, 4'h0);
      chk(rail_pin_drive, c[9] && !c[6] && c[0]);
      chk(lowest_to_agnd, 1'b0);
      ahb(1'b0, LBS_STATUS_OFS, 32'h0);
      chk(rd[ST_PUMP_RUN], gen && psel && c[8]);
      chk(rd[ST_RAIL_IN], c[9] && c[6]);
      chk(rd[ST_COMS_LO +: 4], (1 << ncom) - 1);
   endtask
   // main sequence
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rstn = 1'b0;
      fail_count = 0;
      checked = 0;
      mem = '{default: 32'h0};
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      ahb(1'b0, LBS_CTRL_OFS, 32'h0);
      chk(rd, LBS_CTRL_RESET);
      ahb(1'b1, 8'h08, 32'hffff_ffff);
      ahb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0);
      $display("reset and unmapped access done");
      st = 32'd86585;
      for (int i = 0; i < 64; i++) begin
         st = xs(st);
         c = st & LBS_CTRL_MASK;
         c[0] = c[0] | (i % 4 != 0);
         if (c[9] && !c[5]) c[7] = 1'b0;
         st = xs(st);
         mem[i%4] = st;
         ahb(1'b1, LBS_MEM_OFS + 8'(4*(i%4)), st);
         ahb(1'b1, LBS_CTRL_OFS, c);
         repeat (3) @(posedge core_clk);
         expect_all();
      end
      $display("random configurations done");
      ahb(1'b0, LBS_CTRL_OFS, 32'h0);
      chk(rd, c);
      $display("readback done");
      end_of_test();
   end
endmodule
`default_nettype wire
